// >>> hdl/quadrature_encoder_defs.vh
`ifndef QUADRATURE_ENCODER_DEFS_VH
`define QUADRATURE_ENCODER_DEFS_VH

// register byte offsets
`define QE_OFF_CONTROL 8'h00
`define QE_OFF_STATUS 8'h04
`define QE_OFF_MAXIMUM 8'h08
`define QE_OFF_COUNT 8'h0C
`define QE_OFF_MASK 8'h10
`define QE_OFF_CLEAR 8'h14
`define QE_OFF_LOAD_MAX 8'h18

// control field positions
`define QE_CTL_ENABLE 0
`define QE_CTL_OVER_IRQ_EN 2
`define QE_CTL_UNDER_IRQ_EN 3
`define QE_CTL_EDGE_IRQ_EN 5
`define QE_CTL_FIXED_DIR 6
`define QE_CTL_A_INVERT 7
`define QE_CTL_B_INVERT 8
`define QE_CTL_FILTER_EN 10
`define QE_CTL_WIDTH 16
// writable control bits; reserved bits 15-11, 9, 4 and 1 read as zero
`define QE_CTL_WR_MASK 16'h05ED
`define QE_CTL_RESET 16'h0000

// status field positions, shared with the mask register
`define QE_STA_DIR 0
`define QE_STA_OVER 1
`define QE_STA_UNDER 2
`define QE_STA_EDGE 4
`define QE_STA_WIDTH 5
`define QE_MASK_RESET 5'h16
`define QE_MASK_WR_MASK 5'h16

// counter reset values
`define QE_COUNT_RESET 16'h0000
`define QE_MAX_RESET 16'hFFFF

// edge filter: phase-b transitions that make one full pulse
`define QE_FILTER_PULSE 2'h2

`endif

// >>> hdl/sync_two_flop.v
`timescale 1ns/10ps
module sync_two_flop #(
  parameter WIDTH = 1
) (
  input wire clk_in, // sampling clock
  input wire rstn_in, // async reset, active low
  input wire [WIDTH-1:0] d_in, // asynchronous input
  output wire [WIDTH-1:0] q_out // synchronised output
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] q_r;

  // meta_r feeds q_r only, never any other logic
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= {WIDTH{1'b0}};
      q_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule // sync_two_flop

// >>> hdl/quadrature_encoder_counter.v
`timescale 1ns/10ps
`include "quadrature_encoder_defs.vh"
module quadrature_encoder_counter #(
  parameter ADDR_W = 8,
  parameter DATA_W = 32,
  parameter COUNT_W = 16,
  parameter [COUNT_W-1:0] MAX_RESET = `QE_MAX_RESET
) (
  input wire ref_clk_in, // system clock, 50 MHz
  input wire rstn_in, // async reset, active low
  input wire [ADDR_W-1:0] addr_in, // register byte address
  input wire [DATA_W-1:0] wdata_in, // write data
  input wire wr_in, // write strobe, one cycle
  input wire rd_in, // read strobe, one cycle
  output wire [DATA_W-1:0] rdata_out, // read data, cycle after rd_in
  input wire phase_a_input_in, // encoder phase a pin
  input wire phase_b_input_in, // encoder phase b pin
  output wire irq_out // level interrupt, active high
);

  localparam [COUNT_W-1:0] COUNT_ZERO = `QE_COUNT_RESET;
  localparam [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

  // registers
  reg [`QE_CTL_WIDTH-1:0] control_r;
  reg [`QE_STA_WIDTH-1:0] status_r;
  reg [`QE_STA_WIDTH-1:0] mask_r;
  reg [COUNT_W-1:0] maximum_r;
  reg [COUNT_W-1:0] count_r;
  reg [COUNT_W-1:0] count_gray_r;
  reg dir_up_r;
  reg [DATA_W-1:0] rdata_r;

  // input tracking
  reg a_prev_r;
  reg b_prev_r;
  reg [1:0] b_pulse_r;

  reg [`QE_CTL_WIDTH-1:0] control_nxt;
  reg [`QE_STA_WIDTH-1:0] status_nxt;
  reg [`QE_STA_WIDTH-1:0] mask_nxt;
  reg [COUNT_W-1:0] maximum_nxt;
  reg [COUNT_W-1:0] count_nxt;
  reg dir_up_nxt;
  reg [1:0] b_pulse_nxt;
  reg [DATA_W-1:0] rd_val;

  wire a_sync;
  wire b_sync;

  sync_two_flop #(
    .WIDTH(1)
  ) u_sync_a (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .d_in(phase_a_input_in),
    .q_out(a_sync)
  );

  sync_two_flop #(
    .WIDTH(1)
  ) u_sync_b (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .d_in(phase_b_input_in),
    .q_out(b_sync)
  );

  // control fields
  wire enable = control_r[`QE_CTL_ENABLE];
  wire over_irq_en = control_r[`QE_CTL_OVER_IRQ_EN];
  wire under_irq_en = control_r[`QE_CTL_UNDER_IRQ_EN];
  wire edge_irq_en = control_r[`QE_CTL_EDGE_IRQ_EN];
  wire fixed_dir = control_r[`QE_CTL_FIXED_DIR];
  wire a_invert = control_r[`QE_CTL_A_INVERT];
  wire b_invert = control_r[`QE_CTL_B_INVERT];
  wire filter_en = control_r[`QE_CTL_FILTER_EN];

  // bus decode
  wire sel_control = (addr_in == `QE_OFF_CONTROL);
  wire sel_status = (addr_in == `QE_OFF_STATUS);
  wire sel_maximum = (addr_in == `QE_OFF_MAXIMUM);
  wire sel_count = (addr_in == `QE_OFF_COUNT);
  wire sel_mask = (addr_in == `QE_OFF_MASK);
  wire sel_clear = (addr_in == `QE_OFF_CLEAR);
  wire sel_load_max = (addr_in == `QE_OFF_LOAD_MAX);

  wire wr_control = wr_in & sel_control;
  wire wr_maximum = wr_in & sel_maximum;
  wire wr_count = wr_in & sel_count;
  wire wr_mask = wr_in & sel_mask;
  wire wr_clear = wr_in & sel_clear;
  wire wr_load_max = wr_in & sel_load_max;
  wire rd_status = rd_in & sel_status;

  // invert phase a before any use
  wire a_level = a_sync ^ a_invert;
  // direction from phase b, optionally inverted
  wire b_level = b_sync ^ b_invert;

  wire a_rise = enable & a_level & ~a_prev_r;
  wire b_toggle = enable & (b_sync != b_prev_r);

  // a full high or low pulse on b qualifies the edge
  wire b_pulse_seen = (b_pulse_r == `QE_FILTER_PULSE);
  wire edge_ok = ~filter_en | b_pulse_seen;

  // with fixed_dir set the b-invert bit picks up or down, else phase b does
  wire count_up = fixed_dir ? b_invert : b_level;

  // qualified rising edge steps the counter
  wire step = a_rise & edge_ok;

  wire at_max = (count_r == maximum_r);
  wire at_zero = (count_r == COUNT_ZERO);
  // single-cycle events from the synchronised edge
  wire ev_over = step & count_up & at_max;
  wire ev_under = step & ~count_up & at_zero;
  wire ev_edge = a_rise;

  // binary to gray and back
  function [COUNT_W-1:0] to_gray;
    input [COUNT_W-1:0] bin;
    begin
      to_gray = bin ^ (bin >> 1);
    end
  endfunction

  function [COUNT_W-1:0] from_gray;
    input [COUNT_W-1:0] gray;
    integer i;
    begin
      from_gray[COUNT_W-1] = gray[COUNT_W-1];
      for (i = COUNT_W - 2; i >= 0; i = i - 1) begin
        from_gray[i] = from_gray[i+1] ^ gray[i];
      end
    end
  endfunction

  // control and mask registers
  always @* begin
    control_nxt = control_r;
    mask_nxt = mask_r;
    maximum_nxt = maximum_r;
    // reserved control bits are never stored
    if (wr_control) begin
      control_nxt = wdata_in[`QE_CTL_WIDTH-1:0] & `QE_CTL_WR_MASK;
    end
    if (wr_mask) begin
      mask_nxt = wdata_in[`QE_STA_WIDTH-1:0] & `QE_MASK_WR_MASK;
    end
    if (wr_maximum) begin
      maximum_nxt = wdata_in[COUNT_W-1:0];
    end
  end

  // counter; a software write in the same cycle as a step wins
  always @* begin
    count_nxt = count_r;
    dir_up_nxt = dir_up_r;
    if (step) begin
      dir_up_nxt = count_up;
      // overflow to zero, underflow to maximum
      if (count_up) begin
        count_nxt = at_max ? COUNT_ZERO : count_r + COUNT_ONE;
      end else begin
        count_nxt = at_zero ? maximum_r : count_r - COUNT_ONE;
      end
    end
    if (wr_clear) begin
      count_nxt = COUNT_ZERO;
    end else if (wr_load_max) begin
      count_nxt = maximum_r;
    end else if (wr_count) begin
      count_nxt = wdata_in[COUNT_W-1:0];
    end
  end

  // filter pulse tracker: counts b transitions since the last a rise
  always @* begin
    b_pulse_nxt = b_pulse_r;
    if (!enable) begin
      // first edge after enabling is accepted
      b_pulse_nxt = `QE_FILTER_PULSE;
    end else if (a_rise) begin
      // every rising a-edge restarts the window
      b_pulse_nxt = b_toggle ? 2'h1 : 2'h0;
    end else if (b_toggle && !b_pulse_seen) begin
      b_pulse_nxt = b_pulse_r + 2'h1;
    end
  end

  // status flags
  always @* begin
    status_nxt = status_r;
    // read clears, a new event in the same cycle wins
    if (rd_status) begin
      status_nxt[`QE_STA_EDGE] = 1'b0;
      status_nxt[`QE_STA_UNDER] = 1'b0;
      status_nxt[`QE_STA_OVER] = 1'b0;
    end
    if (ev_edge) begin
      status_nxt[`QE_STA_EDGE] = 1'b1;
    end
    if (ev_under) begin
      status_nxt[`QE_STA_UNDER] = 1'b1;
    end
    if (ev_over) begin
      status_nxt[`QE_STA_OVER] = 1'b1;
    end
    // direction bit follows the last counted step
    status_nxt[`QE_STA_DIR] = dir_up_nxt;
    status_nxt[3] = 1'b0;
  end

  // read mux
  always @* begin
    rd_val = {DATA_W{1'b0}};
    if (sel_control) begin
      rd_val[`QE_CTL_WIDTH-1:0] = control_r;
    end else if (sel_status) begin
      rd_val[`QE_STA_WIDTH-1:0] = status_r;
    end else if (sel_maximum) begin
      rd_val[COUNT_W-1:0] = maximum_r;
    end else if (sel_count) begin
      // count taken from its gray copy, coherent per read
      rd_val[COUNT_W-1:0] = from_gray(count_gray_r);
    end else if (sel_mask) begin
      rd_val[`QE_STA_WIDTH-1:0] = mask_r;
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      control_r <= `QE_CTL_RESET;
      mask_r <= `QE_MASK_RESET;
      maximum_r <= MAX_RESET;
      count_r <= COUNT_ZERO;
      count_gray_r <= COUNT_ZERO;
      dir_up_r <= 1'b0;
      status_r <= {`QE_STA_WIDTH{1'b0}};
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      b_pulse_r <= `QE_FILTER_PULSE;
      rdata_r <= {DATA_W{1'b0}};
    end else begin
      control_r <= control_nxt;
      mask_r <= mask_nxt;
      maximum_r <= maximum_nxt;
      count_r <= count_nxt;
      // gray copy changes one bit per step that does not wrap
      count_gray_r <= to_gray(count_nxt);
      dir_up_r <= dir_up_nxt;
      status_r <= status_nxt;
      a_prev_r <= a_level;
      b_prev_r <= b_sync;
      b_pulse_r <= b_pulse_nxt;
      // read data stand only in the cycle after the strobe
      rdata_r <= rd_in ? rd_val : {DATA_W{1'b0}};
    end
  end

  wire irq_edge = status_r[`QE_STA_EDGE] & mask_r[`QE_STA_EDGE] &
    edge_irq_en;
  wire irq_under = status_r[`QE_STA_UNDER] & mask_r[`QE_STA_UNDER] &
    under_irq_en;
  wire irq_over = status_r[`QE_STA_OVER] & mask_r[`QE_STA_OVER] &
    over_irq_en;

  assign irq_out = irq_edge | irq_under | irq_over;
  assign rdata_out = rdata_r;
endmodule // quadrature_encoder_counter

// >>> tb/encoder_model.sv
`timescale 1ns/10ps
module encoder_model (
  output logic phase_a_out, // shaft phase a
  output logic phase_b_out // shaft phase b
);
  initial begin
    phase_a_out = 1'b0;
    phase_b_out = 1'b0;
  end
  // each level lasts half a 160 ns period, well above the sync minimum
  // pins move on the clock edge by non-blocking assignment, as a bench input
  task set_pins(input logic a, input logic b);
    phase_a_out <= a;
    phase_b_out <= b;
    #80;
  endtask
  task step(input logic b);
    set_pins(1'b0, b);
    set_pins(1'b1, b);
    set_pins(1'b0, b);
  endtask
endmodule // encoder_model

// >>> tb/quadrature_encoder_counter_asserts.sv
`timescale 1ns/10ps
module qe_checker (
  input wire ref_clk_in, // system clock
  input wire rstn_in, // reset, active low
  input wire [7:0] addr_in, // address
  input wire [31:0] wdata_in, // write data
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  input wire [31:0] rdata_out, // read data
  input wire irq_out // interrupt
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_read_idle: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  a_ctl_reserved: assert property (wr_in && addr_in == 8'h00 ##2
    rd_in && addr_in == 8'h00 |=> rdata_out == ($past(wdata_in, 3) & 32'h05ED))
    else $error("control readback wrong");
  a_mask_back: assert property (wr_in && addr_in == 8'h10 ##2
    rd_in && addr_in == 8'h10 |=> rdata_out == ($past(wdata_in, 3) & 32'h16))
    else $error("mask readback wrong");
  a_clear_zero: assert property (wr_in && addr_in == 8'h14 ##2
    rd_in && addr_in == 8'h0C |=> rdata_out == 32'h0)
    else $error("count not zero after clear");
  a_load_max: assert property (wr_in && addr_in == 8'h08 ##2
    wr_in && addr_in == 8'h18 ##2 rd_in && addr_in == 8'h0C
    |=> rdata_out == ($past(wdata_in, 5) & 32'hFFFF))
    else $error("count not maximum after load");
  a_status_rsvd: assert property (rd_in && addr_in == 8'h04
    |=> rdata_out[31:5] == 27'h0 && !rdata_out[3])
    else $error("status reserved bits set");
  a_unmapped: assert property (rd_in && addr_in == 8'h20
    |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_irq_fall: assert property ($fell(irq_out)
    |-> $past(rd_in) || $past(wr_in))
    else $error("interrupt dropped with no access");
  c_irq: cover property ($rose(irq_out));
  c_status: cover property (rd_in && addr_in == 8'h04 ##1 rdata_out[4]);
  c_clear: cover property (wr_in && addr_in == 8'h14);
endmodule // qe_checker
bind quadrature_encoder_counter qe_checker i_qe_checker (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .irq_out(irq_out));

// >>> tb/quadrature_encoder_counter_bench.sv
`timescale 1ns/10ps
module quadrature_encoder_counter_bench;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  wire [31:0] rdata_out;
  wire phase_a, phase_b, irq_out;
  int failures = 0;
  int num_checks = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  quadrature_encoder_counter i_quadrature_encoder_counter (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .phase_a_input_in(phase_a),
    .phase_b_input_in(phase_b), .irq_out(irq_out));
  encoder_model i_encoder_model (.phase_a_out(phase_a), .phase_b_out(phase_b));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk(rdata_out, e);
  endtask
  task irq_is(input logic e);
    @(negedge ref_clk_in);
    chk({31'h0, irq_out}, {31'h0, e});
  endtask
  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hang counts as a failure
  initial begin
    #1000000;
    failures++;
    end_sim();
  end
  // shaft motion goes through these so the model sees bench variables
  task turn(input logic b);
    i_encoder_model.step(b);
  endtask
  task park(input logic a, input logic b);
    i_encoder_model.set_pins(a, b);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h16);
    rd(8'h08, 32'hFFFF);
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    // reserved bits kept zero; enable clear so the invert switch counts nothing
    wr(8'h00, 32'h05EC);
    rd(8'h00, 32'h05EC);
    $display("test reset done");
    wr(8'h00, 32'h1);
    repeat (3) turn(1'b1);
    rd(8'h0C, 32'h3);
    rd(8'h04, 32'h11);
    rd(8'h04, 32'h01);
    turn(1'b0);
    rd(8'h0C, 32'h2);
    rd(8'h04, 32'h10);
    wr(8'h00, 32'h101);
    turn(1'b1);
    rd(8'h0C, 32'h1);
    wr(8'h00, 32'h141);
    turn(1'b0);
    rd(8'h0C, 32'h2);
    wr(8'h00, 32'h041);
    turn(1'b1);
    rd(8'h0C, 32'h1);
    // park a high before inverting so the switch itself is no edge
    wr(8'h00, 32'h0);
    park(1'b1, 1'b1);
    wr(8'h00, 32'h081);
    park(1'b0, 1'b1);
    park(1'b1, 1'b1);
    rd(8'h0C, 32'h2);
    wr(8'h00, 32'h0);
    park(1'b0, 1'b1);
    rd(8'h04, 32'h11);
    turn(1'b1);
    rd(8'h0C, 32'h2);
    rd(8'h04, 32'h01);
    $display("test direction done");
    wr(8'h08, 32'h5);
    wr(8'h0C, 32'h5);
    wr(8'h00, 32'h5);
    turn(1'b1);
    irq_is(1'b1);
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h13);
    irq_is(1'b0);
    wr(8'h00, 32'h9);
    turn(1'b0);
    irq_is(1'b1);
    rd(8'h0C, 32'h5);
    rd(8'h04, 32'h14);
    wr(8'h00, 32'h1);
    turn(1'b0);
    irq_is(1'b0);
    rd(8'h04, 32'h10);
    wr(8'h00, 32'h21);
    turn(1'b0);
    irq_is(1'b1);
    wr(8'h10, 32'hE9);
    rd(8'h10, 32'h0);
    irq_is(1'b0);
    wr(8'h10, 32'hFF);
    rd(8'h04, 32'h10);
    $display("test interrupt done");
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h401);
    turn(1'b1);
    turn(1'b1);
    rd(8'h0C, 32'h4);
    park(1'b0, 1'b0);
    turn(1'b1);
    rd(8'h0C, 32'h5);
    rd(8'h04, 32'h11);
    wr(8'h14, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h08, 32'h1234);
    wr(8'h18, 32'h0);
    rd(8'h0C, 32'h1234);
    $display("test filter and strobes done");
    end_sim();
  end
endmodule // quadrature_encoder_counter_bench
